/* core/eqr_top.sv */
/*
  Error queue reporter: a 30-entry FIFO of signed error codes with an
  overflow slot, class decode into event status set pulses, and clears.
  Assumes all strobes are one-cycle pulses on mclk except talk_only, a
  front-panel level from outside the clock domain.
*/
`timescale 1ns/1ps
`include "eqr_map.svh"
// Functional notes
// - Errors leave in recording order.
// - Full queue: last entry becomes -350.
// - Overflow keeps old entries, drops newest.
// - Thirty entries: 29 ordinary plus overflow.
// - Each read removes the head entry.
// - Empty queue answers code 0.
// - Clear on reset, clear command, leaving talk-only.
// - Class follows the code range.
// - Command errors set status bit 5.
// - Syntax, header, trigger faults are command errors.
// - Command error excludes other classes; a push into a full queue still sets bit 3 too.
// - Execution errors set status bit 4.
// - Execution errors wait for evaluation end.
// - Execution error excludes other classes; a push into a full queue still sets bit 3 too.
// - Device and instrument codes set bit 3.
// - Self-test fail, queue full are device errors.
// - Query errors set status bit 2.
// - Empty read or lost output: query error.
// - Parser codes -101 to -104.
// - Parameter count codes -108, -109.
// - Over-long element gives -112.
// - Too many mantissa digits gives -124.
module eqr_top
  import eqr_pkg::*;
#(
  parameter int        DEPTH    = `EQR_DEPTH,
  parameter eqr_code_t DEV_CODE = `EQR_DEV_GENERIC,
  parameter eqr_code_t QRY_CODE = `EQR_QRY_GENERIC
) (
  // Clock, reset, enable
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       ce,
  // Error sources
  input  wire logic [9:0] parse_flt,
  input  wire logic       exec_err,
  input  wire eqr_code_t  exec_code,
  input  wire logic       eval_done,
  input  wire logic       selftest_fail,
  input  wire logic       oq_read_empty,
  input  wire logic       oq_lost,
  input  wire logic       inst_err,
  input  wire eqr_code_t  inst_code,
  // Clears
  input  wire logic       cls_cmd,
  input  wire logic       talk_only,
  // Host error query
  input  wire logic       err_query,
  output logic            rd_valid,
  output eqr_code_t       rd_code,
  // Status
  output logic [7:0]      esr_set,
  output logic [4:0]      q_count,
  output logic            q_ovf
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int IW = $clog2(DEPTH);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [CW-1:0] ORD  = CW'(DEPTH - 1);

  ////////////////////////////////////////////////////////////////////////
  // Index wrap on the ring
  function automatic logic [IW-1:0] ring_add(input logic [IW-1:0] a,
                                             input logic [CW-1:0] b);
    logic [CW:0] s;
    s = CW'(a) + b;
    if (s >= (CW+1)'(DEPTH)) begin
      s = s - (CW+1)'(DEPTH);
    end
    return IW'(s);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Front-panel mode and parser codes
  logic      talk_s;
  logic      talk_prev_reg;
  logic      talk_prev_next;
  logic      cmd_hit;
  eqr_code_t cmd_code;

  eqr_sync u_sync (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .ce      (ce),
    .d_async (talk_only),
    .q_sync  (talk_s)
  );

  eqr_code_sel u_sel (
    .parse_flt (parse_flt),
    .cmd_hit   (cmd_hit),
    .cmd_code  (cmd_code)
  );

  ////////////////////////////////////////////////////////////////////////
  // Execution errors held until evaluation completes
  logic      exe_pend_reg;
  logic      exe_pend_next;
  eqr_code_t exe_code_reg;
  eqr_code_t exe_code_next;
  logic      exe_fire;
  eqr_code_t exe_out;

  always_comb begin
    exe_fire      = eval_done & (exe_pend_reg | exec_err);
    exe_out       = exec_err ? exec_code : exe_code_reg;
    exe_pend_next = (exe_pend_reg | exec_err) & ~eval_done;
    exe_code_next = exec_err ? exec_code : exe_code_reg;
  end

  ////////////////////////////////////////////////////////////////////////
  // Source pick: one event per cycle yields at most one class; codes outside every range give none
  logic      push;
  eqr_code_t push_code;

  always_comb begin
    push      = 1'b1;
    push_code = `EQR_NO_ERR;
    if (cmd_hit) begin
      push_code = cmd_code;
    end else if (exe_fire) begin
      push_code = exe_out;
    end else if (selftest_fail) begin
      push_code = DEV_CODE;
    end else if (oq_read_empty | oq_lost) begin
      push_code = QRY_CODE;
    end else if (inst_err) begin
      push_code = inst_code;
    end else begin
      push = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Queue state
  eqr_code_t       mem_reg [DEPTH];
  eqr_code_t       mem_next [DEPTH];
  logic [IW-1:0]   head_reg;
  logic [IW-1:0]   head_next;
  logic [CW-1:0]   cnt_reg;
  logic [CW-1:0]   cnt_next;
  logic            ovf_reg;
  logic            ovf_next;
  logic            rd_valid_next;
  eqr_code_t       rd_code_next;
  logic [7:0]      esr_next;
  logic            clr;
  logic            pop;
  logic            ovf_evt;
  logic [CW-1:0]   cnt_a;
  logic [IW-1:0]   head_a;
  logic            ovf_a;
  eqr_class_t      cls;

  always_comb begin
    clr            = cls_cmd | (talk_prev_reg & ~talk_s);
    talk_prev_next = talk_s;
    pop            = err_query & (cnt_reg != '0);
    mem_next       = mem_reg;
    rd_valid_next  = err_query;
    rd_code_next   = `EQR_NO_ERR;
    if (pop) begin
      rd_code_next = mem_reg[head_reg];
    end
    // Pop first, then push against what remains
    cnt_a  = pop ? CW'(cnt_reg - CW'(1)) : cnt_reg;
    head_a = pop ? ring_add(head_reg, CW'(1)) : head_reg;
    ovf_a  = ovf_reg & (cnt_a != '0);
    ovf_evt = push & (ovf_a | (cnt_a == ORD));
    cnt_next  = cnt_a;
    head_next = head_a;
    ovf_next  = ovf_a;
    // Marker must stay last, so nothing queues behind it
    if (push && !ovf_a) begin
      if (cnt_a < ORD) begin
        mem_next[ring_add(head_a, cnt_a)] = push_code;
      end else begin
        mem_next[ring_add(head_a, cnt_a)] = `EQR_OVERFLOW;
        ovf_next = 1'b1;
      end
      cnt_next = CW'(cnt_a + CW'(1));
    end
    // Clear command or leaving talk-only empties the queue, overflow included
    if (clr) begin
      cnt_next  = '0;
      head_next = '0;
      ovf_next  = 1'b0;
    end
    cls      = eqr_classify(push_code);
    esr_next = 8'h00;
    if (push) begin
      esr_next[`EQR_ESR_CMD] = (cls == EQR_CL_CMD);
      esr_next[`EQR_ESR_EXE] = (cls == EQR_CL_EXE);
      esr_next[`EQR_ESR_DEV] = (cls == EQR_CL_DEV) | ovf_evt;
      esr_next[`EQR_ESR_QRY] = (cls == EQR_CL_QRY);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= `EQR_NO_ERR;
      end
      head_reg      <= '0;
      cnt_reg       <= '0;
      ovf_reg       <= 1'b0;
      rd_valid      <= 1'b0;
      rd_code       <= `EQR_NO_ERR;
      esr_set       <= 8'h00;
      exe_pend_reg  <= 1'b0;
      exe_code_reg  <= `EQR_NO_ERR;
      talk_prev_reg <= 1'b0;
    end else if (ce) begin
      mem_reg       <= mem_next;
      head_reg      <= head_next;
      cnt_reg       <= cnt_next;
      ovf_reg       <= ovf_next;
      rd_valid      <= rd_valid_next;
      rd_code       <= rd_code_next;
      esr_set       <= esr_next;
      exe_pend_reg  <= exe_pend_next;
      exe_code_reg  <= exe_code_next;
      talk_prev_reg <= talk_prev_next;
    end
  end

  assign q_count = 5'(cnt_reg);
  assign q_ovf   = ovf_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_empty_zero;
    ce && err_query && cnt_reg == '0 |=> rd_valid && rd_code == `EQR_NO_ERR;
  endproperty
  a_empty_zero: assert property (p_empty_zero) else $error("empty query not 0");

  property p_head_out;
    eqr_code_t h;
    (ce && pop, h = mem_reg[head_reg]) |=> rd_valid && rd_code == h;
  endproperty
  a_head_out: assert property (p_head_out) else $error("head not returned");

  property p_ovf_mark;
    ce && !clr && push && !pop && !ovf_reg && cnt_reg == ORD
      |=> cnt_reg == FULL && ovf_reg && esr_set[3];
  endproperty
  a_ovf_mark: assert property (p_ovf_mark) else $error("overflow mark missing");

  property p_drop_new;
    ce && !clr && push && !pop && ovf_reg |=> $stable(cnt_reg) && $stable(head_reg);
  endproperty
  a_drop_new: assert property (p_drop_new) else $error("older entry disturbed");

  property p_count_max;
    cnt_reg <= FULL;
  endproperty
  a_count_max: assert property (p_count_max) else $error("count above depth");

  property p_pop_dec;
    ce && !clr && pop && !push |=> cnt_reg == CW'($past(cnt_reg) - CW'(1));
  endproperty
  a_pop_dec: assert property (p_pop_dec) else $error("pop did not free slot");

  property p_clear;
    ce && cls_cmd |=> cnt_reg == '0 && !ovf_reg;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");

  property p_cmd_bit;
    ce && cmd_hit |=> esr_set[5] && !esr_set[4] && !esr_set[2];
  endproperty
  a_cmd_bit: assert property (p_cmd_bit) else $error("command bit wrong");

  property p_exe_wait;
    ce && exec_err && !eval_done && !cmd_hit ##1 ce && !eval_done && !cmd_hit && !inst_err
      |=> !esr_set[4];
  endproperty
  a_exe_wait: assert property (p_exe_wait) else $error("early execution error");

  property p_swap;
    ce && !clr && pop && push && !ovf_reg && cnt_reg < ORD |=> $stable(cnt_reg);
  endproperty
  a_swap: assert property (p_swap) else $error("pop and push mismatch");

  property p_exe_bit;
    ce && !cmd_hit && exe_fire && exe_out <= `EQR_EXE_HI && exe_out >= `EQR_EXE_LO
      |=> esr_set[4] && !esr_set[5] && !esr_set[2];
  endproperty
  a_exe_bit: assert property (p_exe_bit) else $error("execution bit wrong");

  property p_dev_bit;
    ce && !cmd_hit && !exe_fire && selftest_fail
      |=> esr_set[3] && !esr_set[5] && !esr_set[4] && !esr_set[2];
  endproperty
  a_dev_bit: assert property (p_dev_bit) else $error("device bit wrong");

  property p_qry_bit;
    ce && !cmd_hit && !exe_fire && !selftest_fail && (oq_read_empty || oq_lost)
      |=> esr_set[2] && !esr_set[5] && !esr_set[4];
  endproperty
  a_qry_bit: assert property (p_qry_bit) else $error("query bit wrong");

  c_overflow: cover property (ce && push && cnt_reg == ORD);
  c_swap:     cover property (ce && pop && push);
  c_switch:   cover property (ce && talk_prev_reg && !talk_s && cnt_reg != '0);
endmodule

/* core/eqr_map.svh */
/*
  Constants for the error queue reporter: depth, error codes, class ranges
  and status bit positions.
  Assumes 16-bit two's complement error codes.
*/
`ifndef EQR_MAP_SVH
`define EQR_MAP_SVH

// Queue geometry
`define EQR_DEPTH       30
`define EQR_CODE_W      16

// Fixed codes
`define EQR_NO_ERR      16'sh0000
`define EQR_OVERFLOW    16'shFEA2
`define EQR_INV_CHAR    16'shFF9B
`define EQR_SYNTAX      16'shFF9A
`define EQR_BAD_SEP     16'shFF99
`define EQR_DATA_TYPE   16'shFF98
`define EQR_GET_IN_MSG  16'shFF97
`define EQR_PAR_EXTRA   16'shFF94
`define EQR_PAR_MISSING 16'shFF93
`define EQR_TOO_LONG    16'shFF90
`define EQR_UNDEF_HDR   16'shFF8F
`define EQR_DIGITS      16'shFF84
`define EQR_DEV_GENERIC 16'shFED4
`define EQR_QRY_GENERIC 16'shFE70

// Class ranges, high end first
`define EQR_CMD_HI      16'shFF9C
`define EQR_CMD_LO      16'shFF39
`define EQR_EXE_HI      16'shFF38
`define EQR_EXE_LO      16'shFED5
`define EQR_DEV_HI      16'shFED4
`define EQR_DEV_LO      16'shFE71
`define EQR_QRY_HI      16'shFE70
`define EQR_QRY_LO      16'shFE0D
`define EQR_INST_LO     16'sh0001

// Standard event status bit positions
`define EQR_ESR_CMD     5
`define EQR_ESR_EXE     4
`define EQR_ESR_DEV     3
`define EQR_ESR_QRY     2

`endif

/* core/eqr_pkg.sv */
/*
  Types and the code classifier for the error queue reporter.
  Assumes eqr_map.svh is on the include path.
*/
package eqr_pkg;
`include "eqr_map.svh"

  typedef logic signed [`EQR_CODE_W-1:0] eqr_code_t;

  typedef enum logic [2:0] {
    EQR_CL_NONE = 3'h0,
    EQR_CL_CMD  = 3'h1,
    EQR_CL_EXE  = 3'h3,
    EQR_CL_DEV  = 3'h2,
    EQR_CL_QRY  = 3'h6
  } eqr_class_t;

  // Classify a code by its range; positive codes are instrument specific
  function automatic eqr_class_t eqr_classify(input eqr_code_t c);
    eqr_class_t r;
    r = EQR_CL_NONE;
    if (c <= `EQR_CMD_HI && c >= `EQR_CMD_LO) begin
      r = EQR_CL_CMD;
    end else if (c <= `EQR_EXE_HI && c >= `EQR_EXE_LO) begin
      r = EQR_CL_EXE;
    end else if ((c <= `EQR_DEV_HI && c >= `EQR_DEV_LO) || c >= `EQR_INST_LO) begin
      r = EQR_CL_DEV;
    end else if (c <= `EQR_QRY_HI && c >= `EQR_QRY_LO) begin
      r = EQR_CL_QRY;
    end
    return r;
  endfunction

endpackage

/* core/eqr_sync.sv */
/*
  Two-flop synchroniser for one level from outside the clock domain.
  Assumes the level changes slowly compared with mclk.
*/
`timescale 1ns/1ps
module eqr_sync (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic ce,
  // Level
  input  wire logic d_async,
  output logic      q_sync
);
  logic meta_reg;
  logic meta_next;
  logic sync_next;

  always_comb begin
    meta_next = ce ? d_async : meta_reg;
    sync_next = ce ? meta_reg : q_sync;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 1'b0;
      q_sync   <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      q_sync   <= sync_next;
    end
  end
endmodule

/* core/eqr_code_sel.sv */
/*
  Turns parser fault strobes into one command-class code, lowest bit first.
  Assumes the strobes are one-cycle pulses on mclk.
*/
`timescale 1ns/1ps
`include "eqr_map.svh"
module eqr_code_sel
  import eqr_pkg::*;
(
  // Parser faults
  input  wire logic [9:0] parse_flt,
  // Selected code
  output logic            cmd_hit,
  output eqr_code_t       cmd_code
);
  localparam eqr_code_t TBL [10] = '{`EQR_INV_CHAR, `EQR_SYNTAX, `EQR_BAD_SEP,
    `EQR_DATA_TYPE, `EQR_GET_IN_MSG, `EQR_PAR_EXTRA, `EQR_PAR_MISSING,
    `EQR_TOO_LONG, `EQR_UNDEF_HDR, `EQR_DIGITS};

  // Only one code per event, so a parse fault yields one command error
  always_comb begin
    cmd_hit  = |parse_flt;
    cmd_code = `EQR_NO_ERR;
    for (int i = 9; i >= 0; i--) begin
      if (parse_flt[i]) begin
        cmd_code = TBL[i];
      end
    end
  end
endmodule

/* tb/eqr_host_model.sv */
/*
  Host side of the error query: issues one query pulse and takes the answer.
  Assumes answers arrive registered, on the same edge that takes the query.
*/
`timescale 1ns/1ps
module eqr_host_model
  import eqr_pkg::*;
(
  // Clock
  mclk,
  // Query port
  err_query,
  rd_valid,
  rd_code
);
  input  wire logic      mclk;
  output logic           err_query;
  input  wire logic      rd_valid;
  input  wire eqr_code_t rd_code;

  initial err_query = 1'h0;

  // Request held until the taking edge, answer read once that edge settles
  task automatic query(output logic v, output eqr_code_t c);
    @(posedge mclk);
    #2 err_query = 1'h1;
    @(posedge mclk);
    #2 err_query = 1'h0;
    v = rd_valid;
    c = rd_code;
  endtask
endmodule

/* tb/tb_top.sv */
/*
  Self-checking bench for the error queue reporter.
  Assumes eqr_pkg is compiled first; expectations come from bench functions.
*/
`timescale 1ns/1ps
module tb_top
  import eqr_pkg::*;
;
  logic       mclk = 1'h0, arst_n = 1'h0, ce = 1'h1, talk_only = 1'h1;
  logic       exec_err = 1'h0, eval_done = 1'h0, selftest_fail = 1'h0, cls_cmd = 1'h0;
  logic       oq_read_empty = 1'h0, oq_lost = 1'h0, inst_err = 1'h0;
  logic [9:0] parse_flt = 10'h000;
  eqr_code_t  exec_code = 16'sh0000, inst_code = 16'sh0000, rd_code, c;
  logic       err_query, rd_valid, q_ovf, v;
  logic [7:0] esr_set;
  logic [4:0] q_count;
  logic [31:0] seed = 32'h5AFA;
  int         fails = 0, n_compared = 0;
  eqr_code_t  expq[$];
  eqr_code_t  pc[10] = '{16'shFF9B, 16'shFF9A, 16'shFF99, 16'shFF98, 16'shFF97,
                         16'shFF94, 16'shFF93, 16'shFF90, 16'shFF8F, 16'shFF84};

  always #20 mclk = ~mclk;

  eqr_top #(.DEPTH(30)) dut (
    .mclk(mclk), .arst_n(arst_n), .ce(ce), .parse_flt(parse_flt), .exec_err(exec_err),
    .exec_code(exec_code), .eval_done(eval_done), .selftest_fail(selftest_fail),
    .oq_read_empty(oq_read_empty), .oq_lost(oq_lost), .inst_err(inst_err),
    .inst_code(inst_code), .cls_cmd(cls_cmd), .talk_only(talk_only),
    .err_query(err_query), .rd_valid(rd_valid), .rd_code(rd_code),
    .esr_set(esr_set), .q_count(q_count), .q_ovf(q_ovf));

  eqr_host_model host (.mclk(mclk), .err_query(err_query), .rd_valid(rd_valid),
    .rd_code(rd_code));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [7:0] exp_esr(input eqr_code_t k);
    if (k <= -100 && k >= -199) return 8'h20;
    if (k <= -200 && k >= -299) return 8'h10;
    if ((k <= -300 && k >= -399) || k >= 1) return 8'h08;
    if (k <= -400 && k >= -499) return 8'h04;
    return 8'h00;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Kinds: 0 parse, 1 exec+done, 2 selftest, 3 empty read, 4 lost, 5 inst,
  // 6 exec held, 7 done alone, 8 clear
  task automatic ev(input int k, input logic [9:0] pf, input eqr_code_t cd);
    @(posedge mclk);
    #2;
    case (k)
      0: parse_flt = pf;
      1: begin
        exec_err = 1'h1;
        eval_done = 1'h1;
        exec_code = cd;
      end
      2: selftest_fail = 1'h1;
      3: oq_read_empty = 1'h1;
      4: oq_lost = 1'h1;
      5: begin
        inst_err = 1'h1;
        inst_code = cd;
      end
      6: begin
        exec_err = 1'h1;
        exec_code = cd;
      end
      7: eval_done = 1'h1;
      default: cls_cmd = 1'h1;
    endcase
    @(posedge mclk);
    #2;
    {parse_flt, exec_err, eval_done, selftest_fail} = 13'h0000;
    {oq_read_empty, oq_lost, inst_err, cls_cmd} = 4'h0;
  endtask

  task automatic pop(input eqr_code_t e);
    host.query(v, c);
    chk(v, 1);
    chk(c, e);
  endtask

  task automatic pop_all();
    while (expq.size() > 0) pop(expq.pop_front());
    chk(q_count, 0);
    pop(16'sh0000);
    chk(q_count, 0);
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    fails++;
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge mclk);
    #2 arst_n = 1'h1;
    chk(q_count, 0);
    pop(16'sh0000);
    $display("test empty done");
    for (int i = 0; i < 10; i++) begin
      ev(0, 10'h001 << i, 0);
      chk(esr_set, 8'h20);
      expq.push_back(pc[i]);
    end
    ev(0, 10'h006, 0);
    chk(esr_set, 8'h20);
    expq.push_back(16'shFF9A);
    chk(q_count, 11);
    pop_all();
    $display("test parser codes done");
    ev(6, 0, 16'shFF22);
    chk(esr_set, 8'h00);
    chk(q_count, 0);
    ev(7, 0, 0);
    chk(esr_set, 8'h10);
    ev(1, 0, 16'shFF1E);
    chk(esr_set, 8'h10);
    ev(2, 0, 0);
    chk(esr_set, 8'h08);
    ev(3, 0, 0);
    chk(esr_set, 8'h04);
    ev(4, 0, 0);
    chk(esr_set, 8'h04);
    expq = '{16'shFF22, 16'shFF1E, 16'shFED4, 16'shFE70, 16'shFE70};
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      c = seed[0] ? {1'h0, seed[15:1]} : -$signed({7'h00, seed[9:1]});
      ev(5, 0, c);
      chk(esr_set, exp_esr(c));
      expq.push_back(c);
    end
    pop_all();
    $display("test classes done");
    for (int i = 0; i < 29; i++) begin
      seed = lfsr(seed);
      c = {1'h0, seed[14:1], 1'h1};
      ev(5, 0, c);
      expq.push_back(c);
    end
    chk(q_ovf, 0);
    ev(5, 0, 16'sh0007);
    chk(esr_set, 8'h08);
    chk(q_count, 30);
    chk(q_ovf, 1);
    ev(0, 10'h001, 0);
    chk(esr_set, 8'h28);
    chk(q_count, 30);
    expq.push_back(16'shFEA2);
    pop_all();
    chk(q_ovf, 0);
    $display("test overflow done");
    ev(5, 0, 3);
    ev(5, 0, 4);
    fork
      ev(5, 0, 9);
      pop(3);
    join
    chk(q_count, 2);
    expq = '{16'sh0004, 16'sh0009};
    pop_all();
    $display("test pop with push done");
    ev(5, 0, 1);
    ev(5, 0, 2);
    ev(8, 0, 0);
    chk(q_count, 0);
    pop(16'sh0000);
    ev(5, 0, 1);
    talk_only = 1'h0;
    repeat (4) @(posedge mclk);
    #2 chk(q_count, 0);
    ev(5, 0, 1);
    arst_n = 1'h0;
    #5 chk(q_count, 0);
    @(posedge mclk);
    #2 arst_n = 1'h1;
    pop(16'sh0000);
    ev(5, 0, 5);
    ce = 1'h0;
    ev(5, 0, 6);
    host.query(v, c);
    chk(v, 0);
    chk(q_count, 1);
    ce = 1'h1;
    pop(16'sh0005);
    chk(q_count, 0);
    $display("test clears done");
    end_of_test();
  end
endmodule
